// ---- common/ovfr_pkg.sv ----
// Package for the output overvoltage fault response block.
// Assumes a single core clock of 250 MHz and an active high asynchronous reset.
package ovfr_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OVFR_CFG_OFFSET = 8'h41;
  localparam int OVFR_ACT_HI = 7;
  localparam int OVFR_ACT_LO = 6;
  localparam int OVFR_RTY_HI = 5;
  localparam int OVFR_RTY_LO = 3;
  localparam int OVFR_DLY_HI = 2;
  localparam int OVFR_DLY_LO = 0;
  localparam logic [1:0] OVFR_ACT_IGNORE = 2'h0;
  localparam logic [1:0] OVFR_ACT_INVALID = 2'h3;
  localparam logic [2:0] OVFR_RTY_LATCH = 3'h0;
  localparam logic [2:0] OVFR_RTY_FOREVER = 3'h7;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int OVFR_CLK_MHZ = 250;
  localparam int OVFR_TICK_US = 1;
  localparam int OVFR_TICK_CYC = OVFR_TICK_US * OVFR_CLK_MHZ;
  // ----------------------------------------------------------------------
  // Control states
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    OVFR_OFF = 6'h01,
    OVFR_RISE = 6'h02,
    OVFR_TONMAX = 6'h04,
    OVFR_WATCH = 6'h08,
    OVFR_RUN = 6'h10,
    OVFR_HICCUP = 6'h20
  } ovfr_state_e;
endpackage

// ---- hw/ovfr_core.sv ----
// Output overvoltage fault response: configuration byte, action selection,
// hiccup restart timing, restart counting and start-up blocking.
// Assumes the fault comparator, enable and faults arrive on the core clock;
// times are counted in microsecond ticks made from the core clock.
//
// Overview of operation
// (R1) Overvoltage trip sets byte, word summary and vout status fault bits.
// (R2) Overvoltage trip raises the host fault notification line.
// (R3) Action 00b keeps regulating through an overvoltage fault.
// (R4) Action 01b or 10b shuts output down and follows retry field.
// (R5) Action 11b write is rejected, flags communication status, notifies host.
// (R6) Retry 0 latches off after shutdown with no restart.
// (R7) Retry 1 to 6 waits hiccup, restarts, latches off after N failures.
// (R8) Retry 7 retries forever until commanded off or start-up succeeds.
// (R9) Hiccup period is one rise time for 0, else K rise times.
// (R10) No shutdown fault for one rise time after ramp clears restart count.
// (R11) Nonzero turn-on maximum limit starts the observation after that limit.
// (R12) Existing overvoltage at enable blocks start-up even when ignoring.
// (R13) Host should set overvoltage limit above start-up input voltage.
// (R14) Byte clears to zero at reset, loads from nonvolatile copy on nvm_load and updates on the fly.
`timescale 1ns/100ps
module ovfr_core #(
  parameter int TIME_W = 16
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Configuration byte access, one write strobe per command; reads follow the command code.
  input wire logic [7:0] cmd_code,
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic [7:0] nvm_cfg,
  input wire logic nvm_load,
  // Converter and fault inputs.
  input wire logic conv_enable,
  input wire logic ov_fault,
  input wire logic other_shutdown_fault,
  input wire logic [TIME_W-1:0] ton_rise_us,
  input wire logic [TIME_W-1:0] ton_max_us,
  // Status clear input; status and control outputs.
  input wire logic status_clear,
  output logic regulate_en,
  output logic latched_off,
  output logic sts_byte_ov,
  output logic sts_word_vout,
  output logic sts_vout_ovf,
  output logic sts_cml_data,
  output logic host_alert,
  output logic [2:0] restart_cnt
);
  // ----------------------------------------------------------------------
  // Configuration byte
  // ----------------------------------------------------------------------
  logic [7:0] cfg_r, cfg_nxt;
  logic cml_r, cml_nxt;
  logic [1:0] act;
  logic [2:0] rty, dly;
  logic cfg_wr;
  assign cfg_wr = wr_stb && (cmd_code == ovfr_pkg::OVFR_CFG_OFFSET);
  assign act = cfg_r[ovfr_pkg::OVFR_ACT_HI:ovfr_pkg::OVFR_ACT_LO];
  assign rty = cfg_r[ovfr_pkg::OVFR_RTY_HI:ovfr_pkg::OVFR_RTY_LO];
  assign dly = cfg_r[ovfr_pkg::OVFR_DLY_HI:ovfr_pkg::OVFR_DLY_LO];

  // Writes take effect at once; an invalid action code leaves the byte alone.
  always_comb begin
    cfg_nxt = cfg_r;
    cml_nxt = cml_r & ~status_clear;
    if (nvm_load) begin
      cfg_nxt = nvm_cfg; // [R14]
    end else if (cfg_wr) begin
      if (wr_data[7:6] == ovfr_pkg::OVFR_ACT_INVALID) begin
        cml_nxt = 1'b1; // [R5]
      end else begin
        cfg_nxt = wr_data; // [R14]
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_r <= 8'h00;
      cml_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      cml_r <= cml_nxt;
    end
  end

  // Reads of other command codes return zero.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= (cmd_code == ovfr_pkg::OVFR_CFG_OFFSET) ? cfg_r : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Microsecond tick
  // ----------------------------------------------------------------------
  logic [8:0] div_r, div_nxt;
  logic tick;
  localparam logic [8:0] TICK_LAST = 9'(ovfr_pkg::OVFR_TICK_CYC - 1);
  assign tick = (div_r == TICK_LAST);
  always_comb begin
    div_nxt = tick ? 9'h000 : 9'(div_r + 9'h001);
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_r <= 9'h000;
    end else begin
      div_r <= div_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  ovfr_pkg::ovfr_state_e st_r, st_nxt;
  logic [TIME_W+2:0] tmr_r, tmr_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [2:0] hic_r, hic_nxt;
  logic ov_r, ov_nxt;
  logic shut_fault, ov_shut, tdone;
  logic [TIME_W+2:0] hic_len;
  assign ov_shut = ov_fault && (act != ovfr_pkg::OVFR_ACT_IGNORE); // [R4]
  assign shut_fault = ov_shut || other_shutdown_fault;
  assign tdone = (tmr_r == '0) || (tick && tmr_r == (TIME_W+3)'(1));
  // Zero and one both give a single rise time.
  assign hic_len = (TIME_W+3)'(ton_rise_us) * (TIME_W+3)'((dly == 3'h0) ? 3'h1 : dly); // [R9]

  always_comb begin
    st_nxt = st_r;
    tmr_nxt = (tick && tmr_r != '0) ? (TIME_W+3)'(tmr_r - 1'b1) : tmr_r;
    cnt_nxt = cnt_r;
    hic_nxt = hic_r;
    // Set beats clear so a trip in the clear cycle is kept.
    ov_nxt = ov_fault | (ov_r & ~status_clear); // [R1]
    case (st_r)
      ovfr_pkg::OVFR_OFF: begin
        // An overvoltage already present stops the start, whatever the action.
        if (conv_enable && !ov_fault && cnt_r == 3'h0 && hic_r == 3'h0) begin // [R12]
          st_nxt = ovfr_pkg::OVFR_RISE;
          tmr_nxt = (TIME_W+3)'(ton_rise_us);
        end
        // Dropping enable is the only release of a latched-off state.
        if (!conv_enable) begin
          cnt_nxt = 3'h0;
          hic_nxt = 3'h0;
        end
      end
      ovfr_pkg::OVFR_RISE, ovfr_pkg::OVFR_TONMAX, ovfr_pkg::OVFR_WATCH: begin
        if (!conv_enable) begin
          st_nxt = ovfr_pkg::OVFR_OFF;
        end else if (shut_fault) begin
          st_nxt = ovfr_pkg::OVFR_HICCUP;
          tmr_nxt = hic_len;
        end else if (tdone) begin
          if (st_r == ovfr_pkg::OVFR_RISE && ton_max_us != '0) begin
            st_nxt = ovfr_pkg::OVFR_TONMAX; // [R11]
            tmr_nxt = (TIME_W+3)'(ton_max_us);
          end else if (st_r != ovfr_pkg::OVFR_WATCH) begin
            st_nxt = ovfr_pkg::OVFR_WATCH;
            tmr_nxt = (TIME_W+3)'(ton_rise_us);
          end else begin
            st_nxt = ovfr_pkg::OVFR_RUN;
            cnt_nxt = 3'h0; // [R10]
          end
        end
      end
      ovfr_pkg::OVFR_RUN: begin
        if (!conv_enable) begin
          st_nxt = ovfr_pkg::OVFR_OFF;
        end else if (shut_fault) begin
          st_nxt = ovfr_pkg::OVFR_HICCUP;
          tmr_nxt = hic_len;
        end
      end
      ovfr_pkg::OVFR_HICCUP: begin
        if (!conv_enable) begin
          st_nxt = ovfr_pkg::OVFR_OFF; // [R8]
          hic_nxt = 3'h0;
        end else if (rty == ovfr_pkg::OVFR_RTY_LATCH || (rty != ovfr_pkg::OVFR_RTY_FOREVER
                     && cnt_r >= rty)) begin
          // The flag keeps the block off even though enable stays high.
          st_nxt = ovfr_pkg::OVFR_OFF; // [R6] [R7]
          hic_nxt = 3'h1;
        end else if (tdone) begin
          st_nxt = ovfr_pkg::OVFR_RISE;
          tmr_nxt = (TIME_W+3)'(ton_rise_us);
          if (rty != ovfr_pkg::OVFR_RTY_FOREVER) cnt_nxt = 3'(cnt_r + 3'h1); // [R7]
        end
      end
      default: begin
        st_nxt = ovfr_pkg::OVFR_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= ovfr_pkg::OVFR_OFF;
      tmr_r <= '0;
      cnt_r <= 3'h0;
      hic_r <= 3'h0;
      ov_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      cnt_r <= cnt_nxt;
      hic_r <= hic_nxt;
      ov_r <= ov_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Latched off stays until enable drops; that is the only release path.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regulate_en <= 1'b0;
      latched_off <= 1'b0;
    end else begin
      regulate_en <= (st_nxt != ovfr_pkg::OVFR_OFF) && (st_nxt != ovfr_pkg::OVFR_HICCUP); // [R3]
      latched_off <= (st_nxt == ovfr_pkg::OVFR_OFF) && (hic_nxt != 3'h0);
    end
  end
  assign sts_byte_ov = ov_r; // [R1]
  assign sts_word_vout = ov_r;
  assign sts_vout_ovf = ov_r;
  assign sts_cml_data = cml_r;
  assign host_alert = ov_r | cml_r; // [R2] [R5]
  assign restart_cnt = cnt_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Assertions watch what this block drives; the inputs are taken as given.
  sequence s_trip;
    ov_fault && (act != ovfr_pkg::OVFR_ACT_IGNORE) && st_r == ovfr_pkg::OVFR_RUN && conv_enable;
  endsequence
  // A hiccup wait under a bounded retry count, where the give-up test runs.
  sequence s_retry_due;
    st_r == ovfr_pkg::OVFR_HICCUP && conv_enable && rty != ovfr_pkg::OVFR_RTY_FOREVER;
  endsequence
  a_trip_status: assert property (@(posedge ref_clk) disable iff (rst) // [R1]
    ov_fault |=> sts_byte_ov && sts_vout_ovf && sts_word_vout)
    else $error("status bits not set on trip");
  a_trip_alert: assert property (@(posedge ref_clk) disable iff (rst) // [R2]
    ov_fault |=> host_alert)
    else $error("host not alerted on trip");
  a_ignore_run: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
    st_r == ovfr_pkg::OVFR_RUN && conv_enable && !other_shutdown_fault
    && act == ovfr_pkg::OVFR_ACT_IGNORE |=> regulate_en)
    else $error("ignore action stopped regulation");
  a_shut_down: assert property (@(posedge ref_clk) disable iff (rst) // [R4]
    s_trip |=> !regulate_en)
    else $error("shutdown action did not stop output");
  a_bad_write: assert property (@(posedge ref_clk) disable iff (rst) // [R5]
    cfg_wr && !nvm_load && wr_data[7:6] == 2'h3 |=> $stable(cfg_r) && sts_cml_data)
    else $error("invalid action accepted");
  a_latch_zero: assert property (@(posedge ref_clk) disable iff (rst) // [R6]
    st_r == ovfr_pkg::OVFR_HICCUP && conv_enable && rty == 3'h0
    |=> st_r == ovfr_pkg::OVFR_OFF)
    else $error("retry zero did not latch off");
  a_count_limit: assert property (@(posedge ref_clk) disable iff (rst) // [R7]
    s_retry_due ##0 cnt_r >= rty |=> st_r == ovfr_pkg::OVFR_OFF && latched_off)
    else $error("bounded retry did not latch off");
  a_forever_cnt: assert property (@(posedge ref_clk) disable iff (rst) // [R8]
    rty == 3'h7 && st_r == ovfr_pkg::OVFR_HICCUP && conv_enable |=> $stable(cnt_r))
    else $error("indefinite retry moved the counter");
  a_success_clr: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
    st_r == ovfr_pkg::OVFR_WATCH && st_nxt == ovfr_pkg::OVFR_RUN |=> cnt_r == 3'h0)
    else $error("counter not cleared on success");
  a_start_block: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
    st_r == ovfr_pkg::OVFR_OFF && ov_fault |=> st_r == ovfr_pkg::OVFR_OFF)
    else $error("started with fault present");
  // Retry steps and the latch that ends them.
  a_latch_hold: assert property (@(posedge ref_clk) disable iff (rst) // [R6] [R7]
    latched_off && conv_enable |=> latched_off && !regulate_en)
    else $error("latched off state left while enabled");
  a_retry_step: assert property (@(posedge ref_clk) disable iff (rst) // [R7]
    s_retry_due ##0 (cnt_r < rty && tdone) |=> st_r == ovfr_pkg::OVFR_RISE
    && cnt_r == 3'($past(cnt_r) + 3'h1))
    else $error("restart attempt not counted");
  a_hiccup_off: assert property (@(posedge ref_clk) disable iff (rst) // [R4]
    st_r == ovfr_pkg::OVFR_HICCUP |-> !regulate_en)
    else $error("output on during hiccup wait");
  // The turn-on limit inserts its own wait before the success window.
  a_tonmax_step: assert property (@(posedge ref_clk) disable iff (rst) // [R11]
    st_r == ovfr_pkg::OVFR_RISE && conv_enable && !shut_fault && tdone
    && ton_max_us != '0 |=> st_r == ovfr_pkg::OVFR_TONMAX)
    else $error("turn-on limit wait skipped");
  // Host writes and stored-copy loads land on the next edge.
  a_cfg_write: assert property (@(posedge ref_clk) disable iff (rst) // [R14]
    cfg_wr && !nvm_load && wr_data[7:6] != ovfr_pkg::OVFR_ACT_INVALID
    |=> cfg_r == $past(wr_data))
    else $error("valid write not applied");
  a_cfg_load: assert property (@(posedge ref_clk) disable iff (rst) // [R14]
    nvm_load |=> cfg_r == $past(nvm_cfg))
    else $error("stored copy not loaded");
endmodule

// ---- tb/ovfr_host.sv ----
// Host model: writes, reads and stored-copy loads of the config byte.
// Assumes the core clock; it drives 1 ns after each rising edge.
`timescale 1ns/100ps
module ovfr_host (
  // Clock.
  input wire logic ref_clk,
  // Command side.
  output logic [7:0] cmd_code,
  output logic wr_stb,
  output logic [7:0] wr_data,
  output logic [7:0] nvm_cfg,
  output logic nvm_load,
  input wire logic [7:0] rd_data
);
  // Idle values at time zero.
  initial begin
    cmd_code = 8'h00;
    wr_stb = 1'b0;
    wr_data = 8'h00;
    nvm_cfg = 8'h00;
    nvm_load = 1'b0;
  end
  // One byte write; the limit is assumed set above start-up input voltage.
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    @(posedge ref_clk);
    #1;
    cmd_code = c;
    wr_data = v;
    wr_stb = 1'b1;
    @(posedge ref_clk);
    #1;
    wr_stb = 1'b0;
    wr_data = ~v; // Released data shows the inverse, not the old value.
  endtask
  // Read: the answer is registered, so it is taken one edge later.
  task automatic rd(input logic [7:0] c, output logic [7:0] v);
    @(posedge ref_clk);
    #1;
    cmd_code = c;
    @(posedge ref_clk);
    #1;
    v = rd_data;
  endtask
  // Stored-copy load as done after power-on.
  task automatic load(input logic [7:0] v);
    @(posedge ref_clk);
    #1;
    nvm_cfg = v;
    nvm_load = 1'b1;
    @(posedge ref_clk);
    #1;
    nvm_load = 1'b0;
  endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the overvoltage fault response block.
// Assumes ovfr_core and the host model on one 250 MHz clock.
`timescale 1ns/100ps
module tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] cmd_code, wr_data, rd_data, nvm_cfg, d;
  logic wr_stb, nvm_load, regulate_en, latched_off, sts_byte_ov;
  logic sts_word_vout, sts_vout_ovf, sts_cml_data, host_alert;
  logic [2:0] restart_cnt;
  logic conv_enable = 1'b0;
  logic ov_fault = 1'b0;
  logic status_clear = 1'b0;
  logic other_shutdown_fault = 1'b0;
  logic [15:0] ton_rise_us = 16'h0001;
  logic [15:0] ton_max_us = 16'h0000;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  // Clock of 4 ns period.
  always #2 ref_clk = ~ref_clk;
  ovfr_host i_ovfr_host (.ref_clk(ref_clk), .cmd_code(cmd_code), .wr_stb(wr_stb),
    .wr_data(wr_data), .nvm_cfg(nvm_cfg), .nvm_load(nvm_load), .rd_data(rd_data));
  ovfr_core i_ovfr_core (.ref_clk(ref_clk), .rst(rst), .cmd_code(cmd_code),
    .wr_stb(wr_stb), .wr_data(wr_data), .rd_data(rd_data), .nvm_cfg(nvm_cfg),
    .nvm_load(nvm_load), .conv_enable(conv_enable), .ov_fault(ov_fault),
    .other_shutdown_fault(other_shutdown_fault),
    .ton_rise_us(ton_rise_us), .ton_max_us(ton_max_us),
    .status_clear(status_clear), .regulate_en(regulate_en), .latched_off(latched_off),
    .sts_byte_ov(sts_byte_ov), .sts_word_vout(sts_word_vout),
    .sts_vout_ovf(sts_vout_ovf), .sts_cml_data(sts_cml_data),
    .host_alert(host_alert), .restart_cnt(restart_cnt));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rchk(input string s, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      fails++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", s, lo, hi, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // Waits are bounded so a dead output cannot hang the run.
  task automatic wait_reg;
    n = 0;
    while (regulate_en !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic wait_cnt0;
    n = 0;
    while (restart_cnt !== 3'h0 && n < 5000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic trip;
    ov_fault = 1'b1;
    tick(1);
    ov_fault = 1'b0;
  endtask
  task automatic clear_all;
    conv_enable = 1'b0;
    status_clear = 1'b1;
    tick(1);
    status_clear = 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Cycle ceiling well above the expected run of at most about 11000 cycles.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      report_and_stop();
    end
  end
  // Main sequence.
  initial begin
    tick(3);
    rst = 1'b0;
    i_ovfr_host.rd(8'h41, d);
    chk("cfg reset", 8'h00, d);
    i_ovfr_host.load(8'h4a);
    i_ovfr_host.rd(8'h41, d);
    chk("cfg load", 8'h4a, d);
    i_ovfr_host.wr(8'h41, 8'h55);
    i_ovfr_host.rd(8'h41, d);
    chk("cfg write", 8'h55, d);
    i_ovfr_host.rd(8'h40, d);
    chk("other cmd", 8'h00, d);
    i_ovfr_host.wr(8'h41, 8'hc0);
    i_ovfr_host.rd(8'h41, d);
    chk("cfg refused", 8'h55, d);
    chk("cml alert", 8'h03, {6'h0, sts_cml_data, host_alert});
    clear_all();
    i_ovfr_host.wr(8'h41, 8'h00);
    conv_enable = 1'b1;
    wait_reg();
    tick(600);
    trip();
    chk("ignore", 8'h1f, {3'h0, regulate_en, sts_byte_ov, sts_word_vout,
      sts_vout_ovf, host_alert});
    clear_all();
    chk("status clear", 8'h00, {6'h0, sts_byte_ov, host_alert});
    ov_fault = 1'b1;
    tick(2);
    conv_enable = 1'b1;
    tick(1000);
    chk("start blocked", 8'h00, {7'h0, regulate_en});
    ov_fault = 1'b0;
    clear_all();
    i_ovfr_host.wr(8'h41, 8'h40);
    conv_enable = 1'b1;
    wait_reg();
    trip();
    chk("shutdown", 8'h00, {7'h0, regulate_en});
    tick(1500);
    chk("latch", 8'h01, {6'h0, regulate_en, latched_off});
    clear_all();
    i_ovfr_host.wr(8'h41, 8'h53);
    conv_enable = 1'b1;
    wait_reg();
    repeat (2) begin
      trip();
      wait_reg();
      rchk("hiccup x3", 500, 760, n);
    end
    trip();
    tick(1500);
    chk("give up", 8'h01, {6'h0, regulate_en, latched_off});
    clear_all();
    i_ovfr_host.wr(8'h41, 8'h78);
    conv_enable = 1'b1;
    wait_reg();
    repeat (7) begin
      trip();
      wait_reg();
      rchk("hiccup x1", 0, 260, n);
      chk("no latch", 8'h00, {7'h0, latched_off});
    end
    // Retry 6: counted attempts, then a clean start clears the count.
    i_ovfr_host.wr(8'h41, 8'h70);
    repeat (3) begin
      trip();
      wait_reg();
    end
    chk("retry count", 8'h03, {5'h0, restart_cnt});
    wait_cnt0();
    rchk("success", 250, 510, n);
    ton_max_us = 16'h0002;
    trip();
    wait_reg();
    // A non-overvoltage shutdown fault in the ramp is a failed attempt too.
    other_shutdown_fault = 1'b1;
    tick(1);
    other_shutdown_fault = 1'b0;
    chk("other fault", 8'h00, {7'h0, regulate_en});
    wait_reg();
    chk("count kept", 8'h02, {5'h0, restart_cnt});
    wait_cnt0();
    rchk("success tonmax", 750, 1010, n);
    report_and_stop();
  end
endmodule
